/* design/interrupt_and_option_control.sv */
// Interrupt enables and flags, option register and AXI4-Lite access to them.
// Operation
// R1: Pull disable bit set turns all pulls off; else pulls follow port latch.
// R2: Edge select bit picks rising (1) or falling (0) external pin edge.
// R3: Timer-0 clock select picks external pin (1) or instruction clock (0).
// R4: Source edge bit picks falling (1) or rising (0) external timer clock.
// R5: Prescaler assign gives shared prescaler to watchdog (1) or timer-0 (0).
// R6: Rate code divides timer-0 by 2^(code+1), watchdog by 2^code.
// R7: Flags set on their condition regardless of any enable.
// R8: Global enable passes unmasked interrupts; clear blocks all.
// R9: Peripheral enable gates every peripheral flag source.
// R10: Timer-0 overflow flag set on rollover; reset keeps the count.
// R11: External pin flag set on selected edge, held until software clears.
// R12: Port change flag set on pin mismatch with latch, held until cleared.
// R13: Port change needs both its enable and the per-pin mask bit.
// R14: Reset keeps the port latch; cleared flag resets again on mismatch.
// R15: Timer-0 and external pin sources each have their own enable.
// R16: Peripheral enables at bits 7..2 and 0; bit 1 reads zero.
// R17: EEPROM flag set when a data write finishes, held until cleared.
// R18: Low-voltage flag set on threshold crossing, cleared by software only.
// R19: Crypto flag set on completion, held until software clears it.
// R20: Each comparator flag sets on its output changing state.
// R21: Oscillator fail flag set on fallback to internal oscillator.
// R22: Timer-1 flag set on rollover, held until written to zero.
// R23: Request when global enable and any enabled core or peripheral flag.
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_option_control
  import irq_option_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins from outside the clock domain
  input wire logic ext_irq_pin,
  input wire logic ext_timer_clock_pin,
  input wire logic [PORT_W-1:0] port_a_pins,
  // Same-domain peripheral sources
  input wire periph_events_t periph_events,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  input wire logic instruction_cycle_clock,
  input wire logic wdt_base_tick,
  input wire logic [PORT_W-1:0] port_output_latch,
  // Results
  output logic irq_request,
  output logic watchdog_tick,
  output logic [PORT_W-1:0] pull_up_enable,
  output logic [PORT_W-1:0] pull_down_enable
);
  if (ADDR_W < 10 || ADDR_W > 12) begin : bad_addr_w
    $error("ADDR_W must be between 10 and 12");
  end

  typedef enum {
    SEL_NONE, SEL_INTERRUPT_CONTROL, SEL_PIR, SEL_OPTION, SEL_PIE, SEL_TMR, SEL_PORT, SEL_MASK
  } sel_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    interrupt_control_t ctrl;
    periph_t pir;
    periph_t pie;
    option_t opt;
    logic [PORT_W-1:0] pin_mask;
    logic [PORT_W-1:0] port_latch;
    logic [PORT_W-1:0] port_s1;
    logic [PORT_W-1:0] port_s2;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic tck_s1;
    logic tck_s2;
    logic tck_prev;
    logic [1:0] cmp_prev;
    logic load_count;
    logic [7:0] load_value;
    logic opt_written;
    logic irq;
    logic [PORT_W-1:0] pull_up;
    logic [PORT_W-1:0] pull_down;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [7:0] tmr_count;
  logic tmr_overflow;

  function automatic sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = 10'(addr[ADDR_W-1:ADDR_LSB]);
    if (idx == IDX_INTERRUPT_CONTROL) begin
      decode = SEL_INTERRUPT_CONTROL;
    end else if (idx == IDX_PERIPHERAL_IRQ_FLAGS) begin
      decode = SEL_PIR;
    end else if (idx == IDX_OPTION_CONFIG) begin
      decode = SEL_OPTION;
    end else if (idx == IDX_PERIPHERAL_IRQ_ENABLES) begin
      decode = SEL_PIE;
    end else if (idx == IDX_TIMER_ZERO_COUNT) begin
      decode = SEL_TMR;
    end else if (idx == IDX_PORT_A_PINS) begin
      decode = SEL_PORT;
    end else if (idx == IDX_PORT_CHANGE_PIN_MASK) begin
      decode = SEL_MASK;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  timer_prescaler u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cur.opt),
    .clear_prescaler(cur.opt_written),
    .load_count(cur.load_count),
    .load_value(cur.load_value),
    .instr_tick(instruction_cycle_clock),
    .ext_rise(cur.tck_s2 && !cur.tck_prev),
    .ext_fall(!cur.tck_s2 && cur.tck_prev),
    .wdt_base_tick(wdt_base_tick),
    .timer_zero_count(tmr_count),
    .overflow(tmr_overflow),
    .watchdog_tick(watchdog_tick)
  );

  always_comb begin
    sel_t wsel;
    sel_t rsel;
    logic do_write;
    logic ext_edge;
    logic port_change;
    logic core_req;
    logic periph_req;
    periph_t pev;
    next_cur = cur;
    wsel = decode(cur.aw_addr);
    rsel = decode(s_axi_araddr);
    next_cur.load_count = 1'b0;
    next_cur.opt_written = 1'b0;

    // Pins pass two flip-flops before any logic looks at them.
    next_cur.ext_s1 = ext_irq_pin;
    next_cur.ext_s2 = cur.ext_s1;
    next_cur.ext_prev = cur.ext_s2;
    next_cur.tck_s1 = ext_timer_clock_pin;
    next_cur.tck_s2 = cur.tck_s1;
    next_cur.tck_prev = cur.tck_s2;
    next_cur.port_s1 = port_a_pins;
    next_cur.port_s2 = cur.port_s1;
    next_cur.cmp_prev = {comparator_two_output, comparator_one_output};

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && cur.awready) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur.wready) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata[7:0];
      next_cur.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end
    do_write = cur.aw_held && cur.w_held && !cur.bvalid;
    if (do_write) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (cur.w_lane0) begin
        if (wsel == SEL_INTERRUPT_CONTROL) begin
          next_cur.ctrl = cur.w_data;
        end else if (wsel == SEL_PIR) begin
          next_cur.pir = cur.w_data & PERIPH_IMPL_MASK; // R22
        end else if (wsel == SEL_OPTION) begin
          next_cur.opt = cur.w_data;
          next_cur.opt_written = 1'b1;
        end else if (wsel == SEL_PIE) begin
          next_cur.pie = cur.w_data & PERIPH_IMPL_MASK; // R16
        end else if (wsel == SEL_TMR) begin
          next_cur.load_count = 1'b1;
          next_cur.load_value = cur.w_data;
        end else if (wsel == SEL_MASK) begin
          next_cur.pin_mask = cur.w_data[PORT_W-1:0];
        end
      end
    end
    next_cur.awready = !next_cur.aw_held && !next_cur.bvalid;
    next_cur.wready = !next_cur.w_held && !next_cur.bvalid;

    // Read channel: one read at a time, data sampled at the taking edge.
    if (s_axi_rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
    if (s_axi_arvalid && cur.arready) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      if (rsel == SEL_INTERRUPT_CONTROL) begin
        next_cur.rdata[7:0] = cur.ctrl;
      end else if (rsel == SEL_PIR) begin
        next_cur.rdata[7:0] = cur.pir;
      end else if (rsel == SEL_OPTION) begin
        next_cur.rdata[7:0] = cur.opt;
      end else if (rsel == SEL_PIE) begin
        next_cur.rdata[7:0] = cur.pie;
      end else if (rsel == SEL_TMR) begin
        next_cur.rdata[7:0] = tmr_count;
      end else if (rsel == SEL_PORT) begin
        // Reading the port refreshes the previous-value latch.
        next_cur.rdata[PORT_W-1:0] = cur.port_s2;
        next_cur.port_latch = cur.port_s2; // R12
      end else if (rsel == SEL_MASK) begin
        next_cur.rdata[PORT_W-1:0] = cur.pin_mask;
      end else begin
        next_cur.rresp = RESP_SLVERR;
      end
    end
    next_cur.arready = !next_cur.rvalid;

    // Hardware events are ORed in after the write, so a set beats a clear.
    ext_edge = cur.ext_s2 != cur.ext_prev;
    ext_edge = ext_edge && (cur.ext_s2 == cur.opt.ext_irq_edge_select); // R2
    // Only masked-in pins may raise the flag; the latch keeps no reset value.
    port_change = |((cur.port_s2 ^ cur.port_latch) & cur.pin_mask); // R13
    if (tmr_overflow) begin // R7
      next_cur.ctrl.timer_zero_overflow_flag = 1'b1; // R10
    end
    if (ext_edge) begin
      next_cur.ctrl.ext_pin_irq_flag = 1'b1; // R11
    end
    if (port_change) begin
      next_cur.ctrl.port_change_flag = 1'b1; // R12
    end
    pev = PERIPH_RESET;
    pev.eeprom_done = periph_events.eeprom_write_done; // R17
    pev.low_voltage = periph_events.low_voltage_cross; // R18
    pev.crypto_done = periph_events.crypto_done; // R19
    pev.comparator_two = comparator_two_output != cur.cmp_prev[1]; // R20
    pev.comparator_one = comparator_one_output != cur.cmp_prev[0]; // R20
    pev.osc_fail = periph_events.osc_fail; // R21
    pev.timer_one = periph_events.timer_one_rollover; // R22
    next_cur.pir = next_cur.pir | pev; // R7

    // Request path works on the present flags and enables.
    core_req = (cur.ctrl.timer_zero_irq_enable && cur.ctrl.timer_zero_overflow_flag) || // R15
      (cur.ctrl.ext_pin_irq_enable && cur.ctrl.ext_pin_irq_flag) || // R15
      (cur.ctrl.port_change_irq_enable && cur.ctrl.port_change_flag); // R13
    periph_req = cur.ctrl.peripheral_irq_enable && |(cur.pir & cur.pie); // R9
    next_cur.irq = cur.ctrl.global_irq_enable && (core_req || periph_req); // R8 R23

    next_cur.pull_up = cur.opt.pull_disable ? '0 : port_output_latch; // R1
    next_cur.pull_down = cur.opt.pull_disable ? '0 : ~port_output_latch; // R1

    if (!aresetn) begin
      next_cur.awready = 1'b0;
      next_cur.wready = 1'b0;
      next_cur.aw_held = 1'b0;
      next_cur.aw_addr = '0;
      next_cur.w_held = 1'b0;
      next_cur.w_data = 8'h00;
      next_cur.w_lane0 = 1'b0;
      next_cur.bvalid = 1'b0;
      next_cur.bresp = RESP_OKAY;
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b0;
      next_cur.rresp = RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      // The flag clears but the latch is kept, so a mismatch sets it again.
      next_cur.ctrl = INTERRUPT_CONTROL_RESET; // R14
      next_cur.pir = PERIPH_RESET;
      next_cur.pie = PERIPH_RESET;
      next_cur.opt = OPTION_RESET;
      next_cur.pin_mask = '0;
      next_cur.port_latch = cur.port_latch; // R14
      next_cur.port_s1 = '0;
      next_cur.port_s2 = '0;
      next_cur.ext_s1 = 1'b0;
      next_cur.ext_s2 = 1'b0;
      next_cur.ext_prev = 1'b0;
      next_cur.tck_s1 = 1'b0;
      next_cur.tck_s2 = 1'b0;
      next_cur.tck_prev = 1'b0;
      next_cur.load_count = 1'b0;
      next_cur.load_value = 8'h00;
      next_cur.opt_written = 1'b0;
      next_cur.irq = 1'b0;
      next_cur.pull_up = '0;
      next_cur.pull_down = '0;
    end
  end

  always_ff @(posedge aclk) begin
    cur <= next_cur;
  end

  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rresp = cur.rresp;
  assign s_axi_rdata = cur.rdata;
  assign irq_request = cur.irq;
  assign pull_up_enable = cur.pull_up;
  assign pull_down_enable = cur.pull_down;
endmodule // interrupt_and_option_control
`default_nettype wire

/* pkg/irq_option_pkg.sv */
// Register map, field layouts and reset values of the interrupt and option block.
package irq_option_pkg;
  // Printed offsets are not all word aligned, so they are kept as indices.
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS = 10'h00c;
  localparam logic [9:0] IDX_OPTION_CONFIG = 10'h081;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLES = 10'h08c;
  localparam logic [9:0] IDX_TIMER_ZERO_COUNT = 10'h001;
  localparam logic [9:0] IDX_PORT_A_PINS = 10'h005;
  localparam logic [9:0] IDX_PORT_CHANGE_PIN_MASK = 10'h096;
  localparam int ADDR_LSB = 2;
  localparam int PORT_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic pull_disable;
    logic ext_irq_edge_select;
    logic timer_zero_clock_select;
    logic timer_zero_source_edge;
    logic prescaler_assign;
    logic [2:0] prescaler_rate;
  } option_t;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic timer_zero_irq_enable;
    logic ext_pin_irq_enable;
    logic port_change_irq_enable;
    logic timer_zero_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_change_flag;
  } interrupt_control_t;

  // Shared layout of the peripheral flag and enable registers.
  typedef struct packed {
    logic eeprom_done;
    logic low_voltage;
    logic crypto_done;
    logic comparator_two;
    logic comparator_one;
    logic osc_fail;
    logic unused;
    logic timer_one;
  } periph_t;

  // Single-cycle peripheral event strobes.
  typedef struct packed {
    logic eeprom_write_done;
    logic low_voltage_cross;
    logic crypto_done;
    logic osc_fail;
    logic timer_one_rollover;
  } periph_events_t;

  localparam option_t OPTION_RESET = 8'hff;
  localparam interrupt_control_t INTERRUPT_CONTROL_RESET = 8'h00;
  localparam periph_t PERIPH_RESET = 8'h00;
  localparam logic [7:0] PERIPH_IMPL_MASK = 8'hfd;
  localparam logic [7:0] PRESCALE_ALL_ONES = 8'hff;
endpackage

/* design/timer_prescaler.sv */
// Timer-0 source select, shared prescaler and watchdog tick generation.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
  import irq_option_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration and control
  input wire option_t cfg,
  input wire logic clear_prescaler,
  input wire logic load_count,
  input wire logic [7:0] load_value,
  // Count sources
  input wire logic instr_tick,
  input wire logic ext_rise,
  input wire logic ext_fall,
  input wire logic wdt_base_tick,
  // Results
  output logic [7:0] timer_zero_count,
  output logic overflow,
  output logic watchdog_tick
);
  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] count;
    logic overflow;
    logic wdt;
  } tstate_t;

  tstate_t cur;
  tstate_t next_cur;

  function automatic logic [7:0] div_mask(input logic [3:0] shift);
    div_mask = ~(PRESCALE_ALL_ONES << shift);
  endfunction

  always_comb begin
    logic src_tick;
    logic timer_inc;
    logic pre_tick;
    logic [7:0] mask;
    timer_inc = 1'b0;
    pre_tick = 1'b0;
    mask = 8'h00;
    next_cur = cur;
    // Timer-0 source: external pin edge or instruction clock.
    src_tick = cfg.timer_zero_clock_select ? // R3
      (cfg.timer_zero_source_edge ? ext_fall : ext_rise) : instr_tick; // R4
    // Prescaler goes to one user only; the other runs at 1:1.
    if (cfg.prescaler_assign) begin // R5
      mask = div_mask({1'b0, cfg.prescaler_rate}); // R6
      pre_tick = wdt_base_tick;
      timer_inc = src_tick;
      next_cur.wdt = pre_tick && ((cur.pre & mask) == mask);
    end else begin
      mask = div_mask({1'b0, cfg.prescaler_rate} + 4'h1); // R6
      pre_tick = src_tick;
      timer_inc = src_tick && ((cur.pre & mask) == mask);
      next_cur.wdt = wdt_base_tick;
    end
    if (clear_prescaler) begin
      next_cur.pre = 8'h00;
    end else if (pre_tick) begin
      next_cur.pre = cur.pre + 8'h01;
    end
    next_cur.overflow = timer_inc && !load_count && (cur.count == 8'hff);
    if (load_count) begin
      next_cur.count = load_value;
    end else if (timer_inc) begin
      next_cur.count = cur.count + 8'h01;
    end
    // Reset leaves the count alone so software sees where it stopped.
    if (!aresetn) begin // R10
      next_cur.pre = 8'h00;
      next_cur.overflow = 1'b0;
      next_cur.wdt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    cur <= next_cur;
  end

  assign timer_zero_count = cur.count;
  assign overflow = cur.overflow;
  assign watchdog_tick = cur.wdt;
endmodule // timer_prescaler
`default_nettype wire

/* dv/irq_option_checker_assertions.sv */
// Concurrent checks on the ports of the interrupt and option block.
`timescale 1ns/1ps
`default_nettype none
module irq_option_checker
  import irq_option_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pulls
  input wire logic [PORT_W-1:0] port_output_latch,
  input wire logic [PORT_W-1:0] pull_up_enable,
  input wire logic [PORT_W-1:0] pull_down_enable
);
  logic [ADDR_W-1:0] read_addr;
  logic periph_read;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // The address is kept because the answer arrives after the request has been dropped.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      read_addr <= s_axi_araddr;
    end
  end
  assign periph_read = (read_addr[ADDR_W-1:2] == IDX_PERIPHERAL_IRQ_FLAGS)
      || (read_addr[ADDR_W-1:2] == IDX_PERIPHERAL_IRQ_ENABLES);
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped or changed");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
  pull_follow_a: assert property ((pull_up_enable | pull_down_enable) != '0 |->
      pull_up_enable == $past(port_output_latch) && pull_down_enable == ~$past(port_output_latch))
      else $error("pulls do not follow latch");
  unimpl_bit_a: assert property (s_axi_rvalid && periph_read |-> !s_axi_rdata[1])
      else $error("unimplemented bit reads one");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
      |-> s_axi_rdata == '0) else $error("error read carries data");
endmodule // irq_option_checker
`default_nettype wire

/* dv/periph_source.sv */
// Model of the peripheral event sources and the core tick generators.
`timescale 1ns/1ps
`default_nettype none
module periph_source
  import irq_option_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Requests from the bench
  input wire logic [4:0] fire,
  // Sources
  output periph_events_t periph_events,
  output logic instruction_cycle_clock,
  output logic wdt_base_tick
);
  logic [1:0] phase;
  initial begin
    phase = 2'h0;
    periph_events = '0;
    instruction_cycle_clock = 1'b0;
    wdt_base_tick = 1'b0;
  end
  // Events are one-cycle strobes; a held level would set a flag every cycle.
  always @(posedge aclk) begin
    phase <= phase + 2'h1;
    periph_events <= fire;
    instruction_cycle_clock <= (phase == 2'h3);
    wdt_base_tick <= phase[0];
  end
endmodule // periph_source
`default_nettype wire

/* dv/test_interrupt_and_option_control.sv */
// Self-checking testbench of the interrupt and option block.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_and_option_control;
  import irq_option_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] e; logic [1:0] r;} row_t;
  localparam logic [11:0] ICN = 12'h02c, PIR = 12'h030, OPT = 12'h204, PIE = 12'h230;
  localparam logic [11:0] CNT = 12'h004, PRT = 12'h014, MSK = 12'h258;
  logic aclk = '0, aresetn = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic ext_irq_pin = '0, ext_timer_clock_pin = '0;
  logic comparator_one_output = '0, comparator_two_output = '0;
  logic [5:0] port_a_pins = '0, port_output_latch = '0, pull_up_enable, pull_down_enable;
  logic [4:0] fire = '0;
  periph_events_t periph_events;
  logic instruction_cycle_clock, wdt_base_tick, irq_request, watchdog_tick;
  int mismatches = 0, check_count = 0, n;
  row_t rows[6] = '{'{OPT, 8'h7a, 8'h7a, RESP_OKAY}, '{ICN, 8'h00, 8'h00, RESP_OKAY},
    '{PIE, 8'hff, 8'hfd, RESP_OKAY}, '{PIR, 8'h02, 8'h00, RESP_OKAY},
    '{MSK, 8'h3f, 8'h3f, RESP_OKAY}, '{12'h100, 8'hff, 8'h00, RESP_SLVERR}};
  logic [7:0] ev_flag[5] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h01};
  initial begin
    forever #25 aclk = ~aclk;
  end
  interrupt_and_option_control #(.ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_irq_pin, .ext_timer_clock_pin, .port_a_pins,
    .periph_events, .comparator_one_output, .comparator_two_output, .instruction_cycle_clock,
    .wdt_base_tick, .port_output_latch, .irq_request, .watchdog_tick, .pull_up_enable,
    .pull_down_enable);
  periph_source src (.aclk, .fire, .periph_events, .instruction_cycle_clock, .wdt_base_tick);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Address and data are offered together and each is dropped once taken.
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [11:0] a, input logic [7:0] e);
    axi_read(a);
    check(name, rd, {24'h000000, e});
  endtask
  task automatic gate(input logic [7:0] i, input logic [7:0] p, input logic e);
    axi_write(ICN, i);
    axi_write(PIE, p);
    cyc(3);
    check("irq request", irq_request, e);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    cyc(2);
    axi_write(CNT, 8'h00);
    rdc("port pins", PRT, 8'h00);
    rdc("option reset", OPT, 8'hff);
    rdc("control reset", ICN, 8'h00);
    rdc("flags reset", PIR, 8'h00);
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].w);
      check("write response", rs, rows[i].r);
      axi_read(rows[i].a);
      check("read data", rd, rows[i].e);
      check("read response", rs, rows[i].r);
    end
    port_output_latch <= 6'h25;
    axi_write(OPT, 8'h28);
    cyc(3);
    check("pull up", pull_up_enable, 6'h25);
    check("pull down", pull_down_enable, 6'h1a);
    axi_write(OPT, 8'haa);
    cyc(3);
    check("pulls off", {pull_up_enable, pull_down_enable}, 12'h000);
    n = 0;
    repeat (80) begin
      @(posedge aclk);
      n += watchdog_tick;
    end
    check("watchdog divided", n inside {[9:11]}, 1'b1);
    axi_write(OPT, 8'h22);
    n = 0;
    repeat (80) begin
      @(posedge aclk);
      n += watchdog_tick;
    end
    check("watchdog undivided", n inside {[39:41]}, 1'b1);
    axi_write(OPT, 8'h38);
    axi_write(CNT, 8'hff);
    ext_timer_clock_pin <= 1'b1;
    cyc(8);
    rdc("no count on rise", ICN, 8'h00);
    ext_timer_clock_pin <= 1'b0;
    cyc(8);
    rdc("count on fall", ICN, 8'h04);
    axi_write(OPT, 8'h08);
    axi_write(CNT, 8'hfd);
    axi_write(ICN, 8'h00);
    cyc(24);
    rdc("internal count", ICN, 8'h04);
    axi_write(OPT, 8'h00);
    axi_write(CNT, 8'h00);
    cyc(40);
    axi_read(CNT);
    check("timer divided", rd inside {[5:6]}, 1'b1);
    axi_write(OPT, 8'h28);
    axi_write(ICN, 8'h00);
    axi_write(PIE, 8'h00);
    for (int i = 0; i < 5; i++) begin
      fire <= 5'h10 >> i;
      @(posedge aclk);
      fire <= 5'h00;
      cyc(3);
      rdc("event flag", PIR, ev_flag[i]);
      axi_write(PIR, 8'h00);
    end
    comparator_one_output <= 1'b1;
    cyc(3);
    rdc("comparator one", PIR, 8'h08);
    comparator_two_output <= 1'b1;
    cyc(3);
    rdc("comparator two", PIR, 8'h18);
    gate(8'hc0, 8'h08, 1'b1);
    gate(8'h80, 8'h08, 1'b0);
    gate(8'h40, 8'h08, 1'b0);
    gate(8'hc0, 8'h00, 1'b0);
    axi_write(PIR, 8'h00);
    axi_write(OPT, 8'h68);
    axi_write(ICN, 8'h10);
    ext_irq_pin <= 1'b1;
    cyc(5);
    rdc("rising edge", ICN, 8'h12);
    ext_irq_pin <= 1'b0;
    axi_write(ICN, 8'h10);
    cyc(5);
    rdc("falling ignored", ICN, 8'h10);
    axi_write(OPT, 8'h28);
    ext_irq_pin <= 1'b1;
    cyc(5);
    ext_irq_pin <= 1'b0;
    cyc(5);
    rdc("falling edge", ICN, 8'h12);
    gate(8'h92, 8'h00, 1'b1);
    gate(8'h82, 8'h00, 1'b0);
    axi_write(ICN, 8'h00);
    axi_write(MSK, 8'h02);
    port_a_pins <= 6'h01;
    cyc(5);
    rdc("masked pin", ICN, 8'h00);
    port_a_pins <= 6'h03;
    cyc(5);
    rdc("port change", ICN, 8'h01);
    gate(8'h88, 8'h00, 1'b1);
    axi_write(CNT, 8'h5c);
    aresetn <= 1'b0;
    cyc(4);
    aresetn <= 1'b1;
    cyc(2);
    rdc("flag after reset", ICN, 8'h00);
    rdc("count kept", CNT, 8'h5c);
    axi_write(MSK, 8'h02);
    cyc(5);
    rdc("mismatch persists", ICN, 8'h01);
    give_verdict();
  end
  initial begin
    cyc(20000);
    mismatches++;
    give_verdict();
  end
endmodule // test_interrupt_and_option_control
bind interrupt_and_option_control irq_option_checker #(.ADDR_W(ADDR_W)) chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .port_output_latch, .pull_up_enable, .pull_down_enable);
`default_nettype wire
